/* File: hw/uart_regs.vh */
/*
 Register offsets, field positions, reset values and bit timing counts for
 the asynchronous serial channel. Assumes an 8-bit register port with a
 4-bit word address and a single peripheral clock.
*/
// What this block does
// R1 - Sync-select bit at 0 runs the channel in start/stop framed mode.
// R2 - Character-length bit at 0 gives eight data bits per frame.
// R3 - Parity-on bit at 0: no parity sent, none checked.
// R4 - Stop-length bit at 0 sends exactly one stop bit per character.
// R5 - Multidrop bit at 0: plain frames, no ID flag, no filtering.
// R6 - Bit-order bit at 0 shifts data least-significant bit first.
// R7 - Data-invert bit at 0 passes data without inversion.
// R8 - Smart-card select at 0 gives ordinary serial interface mode.
// R9 - Half-sampling bit at 0 makes one bit sixteen base-clock cycles.
// R10 - Noise-filter bit at 0 bypasses the digital noise filter.
// R11 - Clock-source field 00 uses the internal baud generator; clock pin free.
// R12 - Software clears enables in the control register before configuring.
// R13 - Control register reads back cleared only once the clear took effect.
// R14 - Status flags set by events regardless of interrupt enables, for polling.
// R15 - Software waits one bit period after setting bit rate before enabling; the bench does so once, later enabling at once and waiting after.
// R16 - Either eight or sixteen base-clock cycles per bit are selectable.
// R17 - Channel leaves reset halted; configurable only after halt is released.
// R18 - Baud generator divides prescaled clock by divisor plus one.
// R19 - Receiver finds falling start edge, samples mid-bit, flags low stop.
// R20 - Overrun raised when a character completes before the previous is read.
`ifndef UART_REGS_VH
`define UART_REGS_VH

`define ADDR_MODE 4'h0
`define ADDR_DIVISOR 4'h1
`define ADDR_CONTROL 4'h2
`define ADDR_TX_DATA 4'h3
`define ADDR_STATUS 4'h4
`define ADDR_RX_DATA 4'h5
`define ADDR_SMARTCARD 4'h6
`define ADDR_EXTENDED 4'h7
`define ADDR_HALT 4'h8

`define MODE_PRESCALE_LO 0
`define MODE_PRESCALE_HI 1
`define MODE_MULTIDROP 2
`define MODE_TWO_STOP 3
`define MODE_ODD_PARITY 4
`define MODE_PARITY_ON 5
`define MODE_CHAR_SEVEN 6
`define MODE_SYNC_SELECT 7

`define CTRL_SRC_LO 0
`define CTRL_SRC_HI 1
`define CTRL_DONE_IRQ 2
`define CTRL_RX_ON 4
`define CTRL_TX_ON 5
`define CTRL_RX_IRQ 6
`define CTRL_TX_IRQ 7

`define SCM_SMARTCARD_SEL 0
`define SCM_INVERT 2
`define SCM_MSB_FIRST 3

`define EXT_HALF_SAMPLING 4
`define EXT_NOISE_FILTER 5

`define STAT_RX_FULL 0
`define STAT_TX_EMPTY 1
`define STAT_TX_END 2
`define STAT_OVERRUN 3
`define STAT_FRAMING 4
`define STAT_PARITY 5

`define MODE_RST 8'h00
`define CTRL_RST 8'h00
`define SCM_RST 8'h00
`define EXT_RST 8'h00
`define DIVISOR_RST 8'hff
`define STATUS_RST 6'h06
`define HALT_RST 1'b1

`define OVS_FULL_LAST 4'hf
`define OVS_FULL_MID 4'h7
`define OVS_HALF_LAST 4'h7
`define OVS_HALF_MID 4'h3

`define PRESCALE_1 6'h00
`define PRESCALE_4 6'h03
`define PRESCALE_16 6'h0f
`define PRESCALE_64 6'h3f

`endif

/* File: hw/baud_gen.v */
/*
 Base-clock tick generator for the serial channel: a power-of-four
 prescaler followed by a divisor counter. Assumes the divisor and prescale
 select are held steady while the generator is enabled.
*/
`include "uart_regs.vh"

module baud_gen #(
  parameter DIV_W = 8
) (
  input wire clk_i,
  input wire rst_b_i,
  input wire enable_i,
  input wire [1:0] prescale_sel_i,
  input wire [DIV_W-1:0] divisor_i,
  output reg tick_o
);

  reg [5:0] pre_cnt;
  reg [DIV_W-1:0] div_cnt;
  wire [5:0] pre_last;

  assign pre_last = (prescale_sel_i == 2'b00) ? `PRESCALE_1 :
                    (prescale_sel_i == 2'b01) ? `PRESCALE_4 :
                    (prescale_sel_i == 2'b10) ? `PRESCALE_16 : `PRESCALE_64;

  // Counters restart from zero on enable, so the first bit after enabling is full length.
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pre_cnt <= 6'h00;
      div_cnt <= {DIV_W{1'b0}};
      tick_o <= 1'b0;
    end else if (!enable_i) begin
      pre_cnt <= 6'h00;
      div_cnt <= {DIV_W{1'b0}};
      tick_o <= 1'b0;
    end else begin
      tick_o <= 1'b0;
      if (pre_cnt >= pre_last) begin
        pre_cnt <= 6'h00;
        if (div_cnt >= divisor_i) begin // R18
          div_cnt <= {DIV_W{1'b0}};
          tick_o <= 1'b1;
        end else begin
          div_cnt <= div_cnt + 1'b1;
        end
      end else begin
        pre_cnt <= pre_cnt + 1'b1;
      end
    end
  end

endmodule

/* File: hw/uart_async_core.v */
/*
 Asynchronous serial transmitter and receiver with mode, control,
 smart-card-mode, extended-mode, divisor, data, status and halt registers.
 Assumes a register master on the same clock and a remote peer whose
 receive line arrives unsynchronised on rxd_i.
*/
// The register addresses and the plain strobed port were left to the implementer.
`include "uart_regs.vh"

module uart_async_core (
  input wire clk_i,
  input wire rst_b_i,
  input wire [3:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rdata_o,
  input wire rxd_i,
  output reg txd_o,
  output reg sck_gpio_free_o
);

  localparam S_IDLE = 3'd0;
  localparam S_START = 3'd1;
  localparam S_DATA = 3'd2;
  localparam S_PAR = 3'd3;
  localparam S_STOP = 3'd4;

  reg [7:0] serial_mode_reg;
  reg [7:0] bit_rate_divisor;
  reg [7:0] serial_control_reg;
  reg [7:0] smartcard_mode_reg;
  reg [7:0] extended_mode_reg;
  reg module_halt_bit;
  reg [7:0] tx_data;
  reg [7:0] rx_data;
  reg [5:0] status;

  // Line synchroniser and optional noise filter.
  reg rx_s1;
  reg rx_s2;
  reg rx_s3;
  reg rx_sync;
  reg [2:0] nf_sh;
  reg nf_out;
  reg line_prev;

  reg [2:0] rx_state;
  reg [3:0] rx_cnt;
  reg [2:0] rx_idx;
  reg [7:0] rx_sh;
  reg rx_par;
  reg rx_perr;
  reg rx_done;
  reg rx_fer_evt;
  reg rx_per_evt;
  reg [7:0] rx_word;

  reg [2:0] tx_state;
  reg [3:0] tx_cnt;
  reg [2:0] tx_idx;
  reg [7:0] tx_sh;
  reg tx_par;
  reg tx_stop_n;
  reg tx_load;
  reg tx_fin;

  wire tick;
  wire wr_ok;
  wire active;
  wire rx_run;
  wire tx_run;
  wire line;
  wire half;
  wire [3:0] ovs_last;
  wire [3:0] ovs_mid;
  wire [2:0] last_bit;
  wire msb_first;
  wire invert;
  wire parity_on;
  wire odd;
  wire [7:0] char_mask;
  wire [2:0] tx_next_pos;

  // Maps the running bit count onto the data register bit it carries.
  function [2:0] bit_pos;
    input [2:0] idx;
    input [2:0] last;
    input msb;
    begin
      bit_pos = msb ? (last - idx) : idx;
    end
  endfunction

  // Only the halt register is writable while the channel is halted.
  assign wr_ok = wr_i && (!module_halt_bit || addr_i == `ADDR_HALT); // R17
  // Sync, multidrop and smart-card modes are not built; the channel idles in them.
  assign active = !module_halt_bit && !serial_mode_reg[`MODE_SYNC_SELECT] // R1
                  && !serial_mode_reg[`MODE_MULTIDROP] // R5
                  && !smartcard_mode_reg[`SCM_SMARTCARD_SEL]; // R8
  assign rx_run = active && serial_control_reg[`CTRL_RX_ON];
  assign tx_run = active && serial_control_reg[`CTRL_TX_ON];
  assign half = extended_mode_reg[`EXT_HALF_SAMPLING];
  assign ovs_last = half ? `OVS_HALF_LAST : `OVS_FULL_LAST; // R9 R16
  assign ovs_mid = half ? `OVS_HALF_MID : `OVS_FULL_MID; // R16
  assign last_bit = serial_mode_reg[`MODE_CHAR_SEVEN] ? 3'd6 : 3'd7; // R2
  assign char_mask = serial_mode_reg[`MODE_CHAR_SEVEN] ? 8'h7f : 8'hff;
  assign msb_first = smartcard_mode_reg[`SCM_MSB_FIRST];
  assign invert = smartcard_mode_reg[`SCM_INVERT];
  assign parity_on = serial_mode_reg[`MODE_PARITY_ON];
  assign odd = serial_mode_reg[`MODE_ODD_PARITY];
  assign line = extended_mode_reg[`EXT_NOISE_FILTER] ? nf_out : rx_sync; // R10
  assign tx_next_pos = bit_pos(tx_idx + 3'd1, last_bit, msb_first);

  // The internal generator is the bit clock for every clock-source setting.
  baud_gen #(
    .DIV_W(8)
  ) u_baud (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .enable_i(rx_run || tx_run),
    .prescale_sel_i({serial_mode_reg[`MODE_PRESCALE_HI], serial_mode_reg[`MODE_PRESCALE_LO]}),
    .divisor_i(bit_rate_divisor),
    .tick_o(tick)
  );

  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
      rx_s3 <= 1'b1;
      rx_sync <= 1'b1;
      nf_sh <= 3'b111;
      nf_out <= 1'b1;
      line_prev <= 1'b1;
    end else begin
      rx_s1 <= rxd_i;
      rx_s2 <= rx_s1;
      rx_s3 <= rx_s2;
      if (rx_s2 == rx_s3) begin
        rx_sync <= rx_s3;
      end
      nf_sh <= {nf_sh[1:0], rx_sync};
      if (nf_sh == 3'b111 || nf_sh == 3'b000) begin
        nf_out <= nf_sh[0];
      end
      line_prev <= line;
    end
  end

  // Register file, status flags and read port.
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      serial_mode_reg <= `MODE_RST;
      bit_rate_divisor <= `DIVISOR_RST;
      serial_control_reg <= `CTRL_RST;
      smartcard_mode_reg <= `SCM_RST;
      extended_mode_reg <= `EXT_RST;
      module_halt_bit <= `HALT_RST;
      tx_data <= 8'h00;
      rx_data <= 8'h00;
      status <= `STATUS_RST;
      rdata_o <= 8'h00;
      sck_gpio_free_o <= 1'b1;
    end else begin
      if (wr_ok) begin
        case (addr_i)
          `ADDR_MODE: serial_mode_reg <= wdata_i;
          `ADDR_DIVISOR: bit_rate_divisor <= wdata_i;
          `ADDR_CONTROL: serial_control_reg <= wdata_i;
          `ADDR_TX_DATA: tx_data <= wdata_i;
          `ADDR_SMARTCARD: smartcard_mode_reg <= wdata_i;
          `ADDR_EXTENDED: extended_mode_reg <= wdata_i;
          `ADDR_HALT: module_halt_bit <= wdata_i[0];
          default: ;
        endcase
      end
      // Flags set on events whatever the interrupt enables hold; set beats clear.
      status[`STAT_RX_FULL] <= (rx_done && !status[`STAT_RX_FULL]) || // R14
        (status[`STAT_RX_FULL] && !(rd_i && addr_i == `ADDR_RX_DATA && !module_halt_bit)
         && !(wr_ok && addr_i == `ADDR_STATUS && wdata_i[`STAT_RX_FULL]));
      status[`STAT_TX_EMPTY] <= tx_load || !tx_run || // R14
        (status[`STAT_TX_EMPTY] && !(wr_ok && addr_i == `ADDR_TX_DATA));
      status[`STAT_TX_END] <= tx_fin || // R14
        (status[`STAT_TX_END] && !(wr_ok && addr_i == `ADDR_TX_DATA));
      status[`STAT_OVERRUN] <= (rx_done && status[`STAT_RX_FULL]) || // R20
        (status[`STAT_OVERRUN] && !(wr_ok && addr_i == `ADDR_STATUS
                                    && wdata_i[`STAT_OVERRUN]));
      status[`STAT_FRAMING] <= (rx_done && rx_fer_evt) || // R19
        (status[`STAT_FRAMING] && !(wr_ok && addr_i == `ADDR_STATUS
                                    && wdata_i[`STAT_FRAMING]));
      status[`STAT_PARITY] <= (rx_done && rx_per_evt) ||
        (status[`STAT_PARITY] && !(wr_ok && addr_i == `ADDR_STATUS
                                   && wdata_i[`STAT_PARITY]));
      // An unread character is kept; the newer one is dropped on overrun.
      if (rx_done && !status[`STAT_RX_FULL]) begin
        rx_data <= rx_word; // R20
      end
      sck_gpio_free_o <= (serial_control_reg[`CTRL_SRC_HI:`CTRL_SRC_LO] == 2'b00); // R11
      if (rd_i) begin
        case (addr_i)
          `ADDR_MODE: rdata_o <= serial_mode_reg;
          `ADDR_DIVISOR: rdata_o <= bit_rate_divisor;
          // Reads the stored value, so a clear is seen only after it has landed.
          `ADDR_CONTROL: rdata_o <= serial_control_reg; // R13
          `ADDR_TX_DATA: rdata_o <= tx_data;
          `ADDR_STATUS: rdata_o <= {2'b00, status};
          `ADDR_RX_DATA: rdata_o <= rx_data;
          `ADDR_SMARTCARD: rdata_o <= smartcard_mode_reg;
          `ADDR_EXTENDED: rdata_o <= extended_mode_reg;
          `ADDR_HALT: rdata_o <= {7'h00, module_halt_bit};
          default: rdata_o <= 8'h00;
        endcase
      end else begin
        rdata_o <= 8'h00;
      end
    end
  end

  // Receiver.
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_state <= S_IDLE;
      rx_cnt <= 4'h0;
      rx_idx <= 3'd0;
      rx_sh <= 8'h00;
      rx_par <= 1'b0;
      rx_perr <= 1'b0;
      rx_done <= 1'b0;
      rx_fer_evt <= 1'b0;
      rx_per_evt <= 1'b0;
      rx_word <= 8'h00;
    end else if (!rx_run) begin
      rx_state <= S_IDLE;
      rx_cnt <= 4'h0;
      rx_done <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      case (rx_state)
        S_IDLE: begin
          if (line_prev && !line) begin // R19
            rx_state <= S_START;
            rx_cnt <= 4'h0;
          end
        end
        S_START: begin
          if (tick) begin
            if (rx_cnt == ovs_mid) begin
              // A start that is high again at mid-bit is a glitch.
              rx_state <= line ? S_IDLE : S_DATA; // R19
              rx_cnt <= 4'h0;
              rx_idx <= 3'd0;
              rx_sh <= 8'h00;
              rx_par <= 1'b0;
              rx_perr <= 1'b0;
            end else begin
              rx_cnt <= rx_cnt + 4'h1;
            end
          end
        end
        S_DATA: begin
          if (tick) begin
            if (rx_cnt == ovs_last) begin
              rx_cnt <= 4'h0;
              rx_sh[bit_pos(rx_idx, last_bit, msb_first)] <= line; // R6
              rx_par <= rx_par ^ line;
              if (rx_idx == last_bit) begin // R2
                rx_state <= parity_on ? S_PAR : S_STOP; // R3
              end else begin
                rx_idx <= rx_idx + 3'd1;
              end
            end else begin
              rx_cnt <= rx_cnt + 4'h1;
            end
          end
        end
        S_PAR: begin
          if (tick) begin
            if (rx_cnt == ovs_last) begin
              rx_cnt <= 4'h0;
              rx_perr <= rx_par ^ line ^ odd;
              rx_state <= S_STOP;
            end else begin
              rx_cnt <= rx_cnt + 4'h1;
            end
          end
        end
        S_STOP: begin
          if (tick) begin
            if (rx_cnt == ovs_last) begin
              rx_cnt <= 4'h0;
              rx_done <= 1'b1;
              rx_fer_evt <= !line; // R19
              rx_per_evt <= rx_perr;
              rx_word <= (invert ? ~rx_sh : rx_sh) & char_mask; // R7
              rx_state <= S_IDLE;
            end else begin
              rx_cnt <= rx_cnt + 4'h1;
            end
          end
        end
        default: rx_state <= S_IDLE;
      endcase
    end
  end

  // Transmitter.
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tx_state <= S_IDLE;
      tx_cnt <= 4'h0;
      tx_idx <= 3'd0;
      tx_sh <= 8'h00;
      tx_par <= 1'b0;
      tx_stop_n <= 1'b0;
      tx_load <= 1'b0;
      tx_fin <= 1'b0;
      txd_o <= 1'b1;
    end else if (!tx_run) begin
      tx_state <= S_IDLE;
      tx_cnt <= 4'h0;
      tx_load <= 1'b0;
      tx_fin <= 1'b0;
      txd_o <= 1'b1;
    end else begin
      tx_load <= 1'b0;
      tx_fin <= 1'b0;
      case (tx_state)
        S_IDLE: begin
          txd_o <= 1'b1;
          // Starting only on a tick keeps the start bit a full bit period at any divisor.
          if (tick && !status[`STAT_TX_EMPTY] && !tx_load) begin // R18
            tx_load <= 1'b1;
            tx_sh <= invert ? ~tx_data : tx_data; // R7
            tx_state <= S_START;
            tx_cnt <= 4'h0;
            txd_o <= 1'b0;
          end
        end
        S_START: begin
          if (tick) begin
            if (tx_cnt == ovs_last) begin
              tx_cnt <= 4'h0;
              tx_idx <= 3'd0;
              txd_o <= tx_sh[bit_pos(3'd0, last_bit, msb_first)]; // R6
              tx_par <= tx_sh[bit_pos(3'd0, last_bit, msb_first)];
              tx_state <= S_DATA;
            end else begin
              tx_cnt <= tx_cnt + 4'h1;
            end
          end
        end
        S_DATA: begin
          if (tick) begin
            if (tx_cnt == ovs_last) begin
              tx_cnt <= 4'h0;
              if (tx_idx == last_bit) begin // R2
                tx_stop_n <= 1'b0;
                if (parity_on) begin // R3
                  txd_o <= tx_par ^ odd;
                  tx_state <= S_PAR;
                end else begin
                  txd_o <= 1'b1;
                  tx_state <= S_STOP;
                end
              end else begin
                tx_idx <= tx_idx + 3'd1;
                txd_o <= tx_sh[tx_next_pos];
                tx_par <= tx_par ^ tx_sh[tx_next_pos];
              end
            end else begin
              tx_cnt <= tx_cnt + 4'h1;
            end
          end
        end
        S_PAR: begin
          if (tick) begin
            if (tx_cnt == ovs_last) begin
              tx_cnt <= 4'h0;
              txd_o <= 1'b1;
              tx_state <= S_STOP;
            end else begin
              tx_cnt <= tx_cnt + 4'h1;
            end
          end
        end
        S_STOP: begin
          if (tick) begin
            if (tx_cnt == ovs_last) begin
              tx_cnt <= 4'h0;
              if (serial_mode_reg[`MODE_TWO_STOP] && !tx_stop_n) begin // R4
                tx_stop_n <= 1'b1;
              end else if (!status[`STAT_TX_EMPTY]) begin
                tx_load <= 1'b1;
                tx_sh <= invert ? ~tx_data : tx_data;
                tx_state <= S_START;
                txd_o <= 1'b0;
              end else begin
                tx_fin <= 1'b1;
                tx_state <= S_IDLE;
              end
            end else begin
              tx_cnt <= tx_cnt + 4'h1;
            end
          end
        end
        default: tx_state <= S_IDLE;
      endcase
    end
  end

endmodule

/* File: verif/uart_async_core_checker.sv */
/*
 Checker for the serial channel's register port and transmit line.
 Assumes it is bound to the channel top and sees only the top's ports.
*/
module uart_async_core_checker (
  input wire clk_i,
  input wire rst_b_i,
  input wire [3:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire [7:0] rdata_o,
  input wire rxd_i,
  input wire txd_o,
  input wire sck_gpio_free_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sh [0:8];
  logic [7:0] rd_exp;
  logic [7:0] rd_mask;
  logic ever_run;
  int low_run;
  int bt;

  function automatic logic [7:0] mask(input logic [3:0] a);
    case (a)
      4'h2: return 8'hf7;
      4'h6: return 8'h0d;
      4'h7: return 8'h30;
      default: return 8'hff;
    endcase
  endfunction

  // A shadow write lands only once the halt bit is clear, except on the halt bit itself.
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < 9; i++) begin
        sh[i] <= (i == 1) ? 8'hff : ((i == 8) ? 8'h01 : 8'h00);
      end
      ever_run <= 1'b0;
      low_run <= 0;
      rd_exp <= 8'h00;
      rd_mask <= 8'h00;
    end else begin
      if (wr_i && addr_i <= 4'h8 && (addr_i == 4'h8 || !sh[8][0])) begin
        sh[addr_i] <= wdata_i;
      end
      if (!sh[8][0]) begin
        ever_run <= 1'b1;
      end
      low_run <= txd_o ? 0 : low_run + 1;
      rd_mask <= mask(addr_i);
      rd_exp <= (addr_i <= 4'h8) ? (sh[addr_i] & mask(addr_i)) : 8'h00;
    end
  end

  assign bt = (int'(sh[1]) + 1) * (1 << (2 * int'(sh[0][1:0]))) * (sh[7][4] ? 8 : 16);

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  property p_ctrl_readback;
    rd_i && addr_i == 4'h2 |=> (rdata_o & rd_mask) == rd_exp;
  endproperty
  a_ctrl_readback: assert property (p_ctrl_readback) else $error("control readback differs");
  property p_cfg_readback;
    rd_i && addr_i inside {4'h0, 4'h1, 4'h6, 4'h7} |=> (rdata_o & rd_mask) == rd_exp;
  endproperty
  a_cfg_readback: assert property (p_cfg_readback) else $error("config readback differs");
  property p_rdata_idle;
    !rd_i |=> rdata_o == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read cycle");
  property p_halt_idle;
    !ever_run |-> txd_o;
  endproperty
  a_halt_idle: assert property (p_halt_idle) else $error("line active while halted");
  property p_bit_min;
    $changed(txd_o) |=> $stable(txd_o) [*7];
  endproperty
  a_bit_min: assert property (p_bit_min) else $error("line bit shorter than 8 cycles");
  property p_low_bound;
    low_run <= 9 * bt;
  endproperty
  a_low_bound: assert property (p_low_bound) else $error("line low past a frame");
  property p_sck;
    wr_i && addr_i == 4'h2 && !sh[8][0] |-> ##2 sck_gpio_free_o == (sh[2][1:0] == 2'b00);
  endproperty
  a_sck: assert property (p_sck) else $error("clock pin release wrong");
  property p_status_reset;
    rd_i && addr_i == 4'h4 && !ever_run |=> rdata_o[5:0] == 6'h06;
  endproperty
  a_status_reset: assert property (p_status_reset) else $error("status not at reset value");

  c_tx_start: cover property ($fell(txd_o));
  c_rx_read: cover property (rd_i && addr_i == 4'h5);
  c_half_tx: cover property ($fell(txd_o) && sh[7][4]);
endmodule

bind uart_async_core uart_async_core_checker uart_async_core_checker_inst (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
  .rd_i(rd_i), .rdata_o(rdata_o), .rxd_i(rxd_i), .txd_o(txd_o),
  .sck_gpio_free_o(sck_gpio_free_o)
);

/* File: verif/serial_peer.sv */
/*
 Remote asynchronous serial peer on the channel's line pins.
 Assumes the bench sets bit_clks to the channel's bit time in clock cycles.
*/
module serial_peer (
  input wire clk_i,
  input wire txd_i,
  output logic rxd_o = 1'b1
);
  timeunit 1ns;
  timeprecision 1ps;
  int bit_clks = 16;
  int last_low = 0;
  int low_run = 0;
  int stop_errs = 0;
  logic [7:0] sr;
  logic [7:0] got_q [$];
  longint start_q [$];

  // The line idles high, so releasing it and idling look the same.
  task automatic send_byte(input logic [7:0] d, input logic stop);
    logic [9:0] f;
    f = {stop, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd_o <= f[i];
      repeat (bit_clks) @(posedge clk_i);
    end
    // One idle bit after each frame, so back-to-back calls never drive the line twice at once.
    rxd_o <= 1'b1;
    repeat (bit_clks) @(posedge clk_i);
  endtask

  always @(posedge clk_i) begin
    if (!txd_i) begin
      low_run <= low_run + 1;
    end else begin
      if (low_run != 0) begin
        last_low <= low_run;
      end
      low_run <= 0;
    end
  end

  initial begin
    forever begin
      @(negedge txd_i);
      start_q.push_back($time);
      repeat (bit_clks / 2) @(posedge clk_i);
      for (int i = 0; i < 8; i++) begin
        repeat (bit_clks) @(posedge clk_i);
        sr[i] = txd_i;
      end
      repeat (bit_clks) @(posedge clk_i);
      if (!txd_i) begin
        stop_errs++;
      end
      got_q.push_back(sr);
    end
  end
endmodule

/* File: verif/testbench.sv */
/*
 Self-checking bench for the serial channel: register tasks plus a peer.
 Assumes a 250 MHz clock and the fastest bit rate unless a test changes it.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  wire [7:0] rdata_o;
  wire rxd_i;
  wire txd_o;
  wire sck_gpio_free_o;
  int n_errors = 0;
  int checked = 0;
  int bt;
  logic [7:0] v;

  uart_async_core uart_async_core_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rxd_i(rxd_i),
    .txd_o(txd_o), .sck_gpio_free_o(sck_gpio_free_o));
  serial_peer serial_peer_inst (.clk_i(clk_i), .txd_i(txd_o), .rxd_o(rxd_i));

  initial begin
    forever #2 clk_i = ~clk_i;
  end

  task automatic tally_and_finish;
    $display("checked=%0d n_errors=%0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_n(input int got, input int exp);
    checked++;
    if (got != exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rd(input logic [3:0] a);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
    @(posedge clk_i);
  endtask

  task automatic rchk(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    rd(a);
    chk8(v & m, e);
  endtask

  // Bounded polling so a stuck flag ends as a mismatch, not a hang.
  task automatic poll(input logic [7:0] m, input logic [7:0] e);
    int k;
    k = 0;
    do begin
      rd(4'h4);
      k++;
    end while ((v & m) !== e && k < 20000);
    chk8(v & m, e);
  endtask

  initial begin
    #400000;
    n_errors++;
    tally_and_finish();
  end

  initial begin
    repeat (12) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
    wr(4'h0, 8'h55);
    rchk(4'h0, 8'hff, 8'h00);
    rchk(4'h4, 8'h3f, 8'h06);
    rchk(4'hf, 8'hff, 8'h00);
    wr(4'h8, 8'h00);
    wr(4'h2, 8'h00);
    rchk(4'h2, 8'hff, 8'h00);
    wr(4'h0, 8'h00);
    wr(4'h6, 8'h00);
    wr(4'h7, 8'h00);
    wr(4'h1, 8'h00);
    rchk(4'h1, 8'hff, 8'h00);
    repeat (16) @(posedge clk_i);
    wr(4'h2, 8'h33);
    @(negedge clk_i) chk8({7'h00, sck_gpio_free_o}, 8'h00);
    @(posedge clk_i);
    wr(4'h2, 8'h30);
    @(negedge clk_i) chk8({7'h00, sck_gpio_free_o}, 8'h01);
    @(posedge clk_i);
    rchk(4'h2, 8'hff, 8'h30);
    wr(4'h3, 8'ha5);
    poll(8'h02, 8'h02);
    wr(4'h3, 8'h3c);
    poll(8'h04, 8'h04);
    chk8(serial_peer_inst.got_q[0], 8'ha5);
    chk8(serial_peer_inst.got_q[1], 8'h3c);
    chk_n(serial_peer_inst.stop_errs, 0);
    chk_n(int'((serial_peer_inst.start_q[1] - serial_peer_inst.start_q[0]) / 4), 160);
    chk_n(serial_peer_inst.last_low, 32);
    serial_peer_inst.send_byte(8'h96, 1'b1);
    poll(8'h01, 8'h01);
    rchk(4'h5, 8'hff, 8'h96);
    rchk(4'h4, 8'h39, 8'h00);
    serial_peer_inst.send_byte(8'h11, 1'b1);
    serial_peer_inst.send_byte(8'h22, 1'b1);
    repeat (8) @(posedge clk_i);
    rchk(4'h4, 8'h09, 8'h09);
    rchk(4'h5, 8'hff, 8'h11);
    wr(4'h4, 8'h08);
    rchk(4'h4, 8'h08, 8'h00);
    serial_peer_inst.send_byte(8'h5a, 1'b0);
    repeat (8) @(posedge clk_i);
    rchk(4'h4, 8'h10, 8'h10);
    wr(4'h4, 8'h39);
    rd(4'h5);
    wr(4'h2, 8'h00);
    wr(4'h7, 8'h10);
    serial_peer_inst.bit_clks = 8;
    wr(4'h2, 8'h30);
    repeat (8) @(posedge clk_i);
    wr(4'h3, 8'hff);
    poll(8'h04, 8'h04);
    chk_n(serial_peer_inst.last_low, 8);
    serial_peer_inst.send_byte(8'hc3, 1'b1);
    poll(8'h01, 8'h01);
    rchk(4'h5, 8'hff, 8'hc3);
    wr(4'h7, 8'h00);
    for (int p = 0; p < 4; p++) begin
      wr(4'h2, 8'h00);
      wr(4'h0, 8'(p));
      wr(4'h1, 8'h01);
      bt = 2 * (1 << (2 * p)) * 16;
      serial_peer_inst.bit_clks = bt;
      wr(4'h2, 8'h30);
      repeat (bt) @(posedge clk_i);
      wr(4'h3, 8'hff);
      poll(8'h04, 8'h04);
      chk_n(serial_peer_inst.last_low, bt);
    end
    tally_and_finish();
  end
endmodule
